// >>> dma_request_router_trigger.sv
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module dma_request_router_trigger
    import dma_route_pkg::*;
#(
    parameter int CHANNELS      = NUM_CHANNELS,
    parameter int TRIGGER_GATE_ENABLE_CHANNELS = NUM_TRIGGER_GATE_ENABLE_CHANNELS
) (
    // Clock and reset
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // AHB-Lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output      logic [31:0]                 hrdata,
    output      logic                        hreadyout,
    output      logic                        hresp,
    // Peripheral request slots (index = slot number)
    input  wire logic [NUM_SLOTS-1:0]        periph_req,
    // Trigger pulses from the periodic_interval_timer
    input  wire logic [TRIGGER_GATE_ENABLE_CHANNELS-1:0]    periodic_interval_timer,
    // Requests towards the DMA controller channels
    output      logic [CHANNELS-1:0]         dma_chan_req
);

    localparam int IW = $clog2(NUM_WORDS);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic route_mode_e decode_mode(input logic [7:0] c);
        if (!c[ROUTE_ENABLE_BIT])
            return MODE_DISABLED;
        else if (c[TRIGGER_GATE_ENABLE_BIT])
            return MODE_PERIODIC;
        else
            return MODE_NORMAL;
    endfunction

    // Lane mask from size and low address bits; misaligned is software's
    // problem, so only the lanes that the size covers are used.
    function automatic logic [3:0] lane_mask(input logic [2:0] sz,
                                             input logic [1:0] a);
        case (sz)
            HSIZE_BYTE: lane_mask = 4'h1 << a;
            HSIZE_HALF: lane_mask = a[1] ? 4'hc : 4'h3;
            default:    lane_mask = 4'hf;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Bus slave: zero wait state, address phase registered
    // ------------------------------------------------------------
    logic          wr_pend_r;
    logic          wr_pend_nxt;
    logic [IW-1:0] wr_idx_r;
    logic [IW-1:0] wr_idx_nxt;
    logic [3:0]    wr_be_r;
    logic [3:0]    wr_be_nxt;
    logic          rd_hit_r;
    logic          rd_hit_nxt;
    logic          access;
    logic          in_map;

    assign access = hsel && hready &&
                    (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign in_map = (haddr[11:0] <= {4'h0, CHANNEL31_ROUTE_CONFIG_OFS});

    always_comb begin
        wr_pend_nxt = 1'b0;
        wr_idx_nxt  = wr_idx_r;
        wr_be_nxt   = wr_be_r;
        rd_hit_nxt  = 1'b0;
        if (access) begin
            wr_idx_nxt  = haddr[IW+1:2];
            wr_be_nxt   = lane_mask(hsize, haddr[1:0]);
            wr_pend_nxt = hwrite && in_map;
            rd_hit_nxt  = !hwrite && in_map;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= '0;
            wr_be_r   <= 4'h0;
            rd_hit_r  <= 1'b0;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r  <= wr_idx_nxt;
            wr_be_r   <= wr_be_nxt;
            rd_hit_r  <= rd_hit_nxt;
        end
    end

    route_cfg_if cfg_bus ();

    assign cfg_bus.wr_en   = wr_pend_r;
    assign cfg_bus.wr_idx  = wr_idx_r;
    assign cfg_bus.wr_be   = wr_be_r;
    assign cfg_bus.wr_data = hwdata;
    // Read address taken in the address phase so data stand registered
    assign cfg_bus.rd_idx  = haddr[IW+1:2];

    route_cfg_store u_store (
        .hclk    (hclk),
        .hresetn (hresetn),
        .cfg     (cfg_bus)
    );

    // Unmapped reads return zero; writes there are dropped
    assign hrdata    = rd_hit_r ? cfg_bus.rd_data : 32'h0000_0000;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ------------------------------------------------------------
    // Source slot vector
    // ------------------------------------------------------------
    logic [NUM_SLOTS-1:0] slot_req;

    always_comb begin
        slot_req = '0;
        for (int s = 1; s <= NUM_PERIPH_SLOTS; s++) begin
            slot_req[s] = periph_req[s];
        end
        for (int s = 0; s < NUM_ALWAYS_SLOTS; s++) begin
            slot_req[FIRST_ALWAYS_SLOT+s] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per-channel routing and trigger gate
    // ------------------------------------------------------------
    logic [CHANNELS-1:0]      sel_req;
    route_mode_e              mode   [CHANNELS];
    logic [TRIGGER_GATE_ENABLE_CHANNELS-1:0] gate_r;
    logic [TRIGGER_GATE_ENABLE_CHANNELS-1:0] gate_nxt;
    logic [TRIGGER_GATE_ENABLE_CHANNELS-1:0] trigger_gate_enable_r;
    logic [TRIGGER_GATE_ENABLE_CHANNELS-1:0] trigger_gate_enable_nxt;

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            mode[c]    = decode_mode(cfg_bus.cfg_flat[c*8 +: 8]);
            sel_req[c] = slot_req[cfg_bus.cfg_flat[c*8 +: SOURCE_SEL_W]];
        end
    end

    // Gate opens on a trigger seen while the request is up and stays open
    // until the request drops; a lone trigger leaves nothing behind.
    always_comb begin
        trigger_gate_enable_nxt = periodic_interval_timer;
        for (int c = 0; c < TRIGGER_GATE_ENABLE_CHANNELS; c++) begin
            if (mode[c] != MODE_PERIODIC || !sel_req[c])
                gate_nxt[c] = 1'b0;
            else if (trigger_gate_enable_r[c])
                gate_nxt[c] = 1'b1;
            else
                gate_nxt[c] = gate_r[c];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_r <= '0;
            trigger_gate_enable_r <= '0;
        end else begin
            gate_r <= gate_nxt;
            trigger_gate_enable_r <= trigger_gate_enable_nxt;
        end
    end

    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            case (mode[c])
                MODE_NORMAL:   dma_chan_req[c] = sel_req[c];
                MODE_PERIODIC: begin
                    if (c < TRIGGER_GATE_ENABLE_CHANNELS)
                        dma_chan_req[c] = sel_req[c] && gate_r[c];
                    else
                        dma_chan_req[c] = sel_req[c];
                end
                default:       dma_chan_req[c] = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_DISABLED_QUIET: assert property (@(posedge hclk) disable iff
        (!hresetn) !cfg_bus.cfg_flat[ROUTE_ENABLE_BIT] |-> !dma_chan_req[0])
        else $error("disabled channel 0 requests");
    AST_NORMAL_PASS: assert property (@(posedge hclk) disable iff
        (!hresetn) mode[4] == MODE_NORMAL |-> dma_chan_req[4] == sel_req[4])
        else $error("normal mode not transparent");
    AST_HOLD_NO_TRIGGER_GATE_ENABLE: assert property (@(posedge hclk) disable iff
        (!hresetn) (mode[0] == MODE_PERIODIC && !gate_r[0] && !trigger_gate_enable_r[0])
        ##1 mode[0] == MODE_PERIODIC |-> !dma_chan_req[0])
        else $error("request passed without trigger");
    AST_OPEN_ON_TRIGGER_GATE_ENABLE: assert property (@(posedge hclk) disable iff
        (!hresetn) (mode[1] == MODE_PERIODIC && sel_req[1] && trigger_gate_enable_r[1])
        |=> gate_r[1])
        else $error("gate failed to open");
    AST_CLOSE_ON_DROP: assert property (@(posedge hclk) disable iff
        (!hresetn) !sel_req[2] |=> !gate_r[2])
        else $error("gate stayed open after drop");
    AST_TRIGGER_GATE_ENABLE_DISCARD: assert property (@(posedge hclk) disable iff
        (!hresetn) (trigger_gate_enable_r[3] && !sel_req[3]) |=> !gate_r[3])
        else $error("idle trigger remembered");
    AST_ALWAYS_ON: assert property (@(posedge hclk) disable iff
        (!hresetn) cfg_bus.cfg_flat[39:32] == 8'hbc |-> dma_chan_req[4])
        else $error("always-on slot not requesting");
    AST_SLOT_ZERO: assert property (@(posedge hclk) disable iff
        (!hresetn) cfg_bus.cfg_flat[SOURCE_SEL_MSB:0] == 6'h00
        |-> !dma_chan_req[0])
        else $error("slot 0 requested");
    AST_PLAIN_TRIGGER_GATE_ENABLE: assert property (@(posedge hclk) disable iff
        (!hresetn) mode[5] == MODE_PERIODIC |-> dma_chan_req[5] == sel_req[5])
        else $error("trigger bit gated plain channel");
    AST_WRITE_LAND: assert property (@(posedge hclk) disable iff
        (!hresetn) (access && hwrite && hsize == HSIZE_WORD
        && haddr[11:0] == 12'h000) ##1 1'b1
        |=> cfg_bus.cfg_flat[31:0] == $past(hwdata))
        else $error("word write to offset 0 lost");
    AST_RESET_OFF: assert property (@(posedge hclk)
        $rose(hresetn) |-> dma_chan_req == '0)
        else $error("channel active after reset");
    AST_RESET_RDATA: assert property (@(posedge hclk)
        $rose(hresetn) |-> hrdata == 32'h0000_0000)
        else $error("read data not idle after reset");
    AST_MODE_PERIODIC: assert property (@(posedge hclk) disable iff
        (!hresetn) cfg_bus.cfg_flat[7:6] == 2'b11
        |-> mode[0] == MODE_PERIODIC)
        else $error("periodic mode not decoded");
    AST_GATE_NEEDS_TRIGGER_GATE_ENABLE: assert property (@(posedge hclk) disable iff
        (!hresetn) $rose(gate_r[3]) |-> $past(trigger_gate_enable_r[3]))
        else $error("gate opened without trigger");
    AST_CLOSED_GATE: assert property (@(posedge hclk) disable iff
        (!hresetn) (mode[2] == MODE_PERIODIC && !gate_r[2])
        |-> !dma_chan_req[2])
        else $error("closed gate passed a request");
    AST_ROUTE_PERIPH: assert property (@(posedge hclk) disable iff
        (!hresetn) (mode[8] == MODE_NORMAL
        && cfg_bus.cfg_flat[69:64] != 6'h00
        && cfg_bus.cfg_flat[69:64] <= 6'd52)
        |-> dma_chan_req[8] == periph_req[cfg_bus.cfg_flat[69:64]])
        else $error("peripheral slot not routed");
    AST_UNASSIGNED: assert property (@(posedge hclk) disable iff
        (!hresetn) (cfg_bus.cfg_flat[69:64] > 6'd52
        && cfg_bus.cfg_flat[69:64] < 6'd60) |-> !dma_chan_req[8])
        else $error("unassigned slot requested");

    // ------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------
    AST_OKAY_ONLY: assert property (@(posedge hclk) disable iff
        (!hresetn) hreadyout && !hresp)
        else $error("bus response not OKAY");
    AST_UNMAPPED_ZERO: assert property (@(posedge hclk) disable iff
        (!hresetn) (access && !hwrite && !in_map)
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_READ_DATA: assert property (@(posedge hclk) disable iff
        (!hresetn) (access && !hwrite && in_map && haddr[4:2] == 3'h0)
        |=> hrdata == cfg_bus.cfg_flat[31:0])
        else $error("word read of offset 0 wrong");
    AST_BYTE_LANE: assert property (@(posedge hclk) disable iff
        (!hresetn) (access && hwrite && hsize == HSIZE_BYTE
        && haddr[11:0] == 12'h005) ##1 1'b1
        |=> cfg_bus.cfg_flat[47:40] == $past(hwdata[15:8])
        && cfg_bus.cfg_flat[39:32] == $past(cfg_bus.cfg_flat[39:32]))
        else $error("byte write to offset 5 wrong");
    AST_HALF_LANE: assert property (@(posedge hclk) disable iff
        (!hresetn) (access && hwrite && hsize == HSIZE_HALF
        && haddr[11:0] == 12'h006) ##1 1'b1
        |=> cfg_bus.cfg_flat[63:48] == $past(hwdata[31:16])
        && cfg_bus.cfg_flat[47:40] == $past(cfg_bus.cfg_flat[47:40]))
        else $error("halfword write to offset 6 wrong");

endmodule // dma_request_router_trigger

// >>> dma_route_pkg.sv
package dma_route_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CHANNELS      = 32;
    localparam int NUM_TRIGGER_GATE_ENABLE_CHANNELS = 4;
    localparam int NUM_SLOTS         = 64;
    localparam int NUM_PERIPH_SLOTS  = 52;
    localparam int FIRST_ALWAYS_SLOT = 60;
    localparam int NUM_ALWAYS_SLOTS  = 4;
    localparam int NUM_WORDS         = NUM_CHANNELS / 4;

    // ------------------------------------------------------------
    // Register map (byte offsets; one config byte per channel)
    // ------------------------------------------------------------
    localparam logic [7:0] CHANNEL0_ROUTE_CONFIG_OFS  = 8'h00;
    localparam logic [7:0] CHANNEL1_ROUTE_CONFIG_OFS  = 8'h01;
    localparam logic [7:0] CHANNEL31_ROUTE_CONFIG_OFS = 8'h1f;
    localparam logic [7:0] CHANNEL_ROUTE_CONFIG_RST   = 8'h00;

    // ------------------------------------------------------------
    // Field layout of channel_route_config
    // ------------------------------------------------------------
    localparam int ROUTE_ENABLE_BIT        = 7;
    localparam int TRIGGER_GATE_ENABLE_BIT = 6;
    localparam int SOURCE_SEL_MSB          = 5;
    localparam int SOURCE_SEL_W            = 6;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] HSIZE_BYTE    = 3'h0;
    localparam logic [2:0] HSIZE_HALF    = 3'h1;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [2:0] {
        MODE_DISABLED = 3'b001,
        MODE_NORMAL   = 3'b010,
        MODE_PERIODIC = 3'b100
    } route_mode_e;

endpackage

// >>> route_cfg_if.sv
`timescale 1ns/1ps
interface route_cfg_if;
    import dma_route_pkg::*;
    logic                          wr_en;
    logic [$clog2(NUM_WORDS)-1:0]  wr_idx;
    logic [3:0]                    wr_be;
    logic [31:0]                   wr_data;
    logic [$clog2(NUM_WORDS)-1:0]  rd_idx;
    logic [31:0]                   rd_data;
    logic [NUM_CHANNELS*8-1:0]     cfg_flat;

    modport host (output wr_en, wr_idx, wr_be, wr_data, rd_idx,
                  input rd_data, cfg_flat);
    modport store (input wr_en, wr_idx, wr_be, wr_data, rd_idx,
                   output rd_data, cfg_flat);
endinterface

// >>> route_cfg_store.sv
`timescale 1ns/1ps
module route_cfg_store
    import dma_route_pkg::*;
(
    // Clock and reset
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // Access port
    route_cfg_if.store  cfg
);

    logic [NUM_CHANNELS*8-1:0] mem_r;
    logic [NUM_CHANNELS*8-1:0] mem_nxt;
    logic [31:0]               rd_r;
    logic [31:0]               rd_nxt;

    // Byte-lane merge of a word write into the channel bytes
    always_comb begin
        mem_nxt = mem_r;
        if (cfg.wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (cfg.wr_be[b]) begin
                    mem_nxt[(int'(cfg.wr_idx)*4+b)*8 +: 8] =
                        cfg.wr_data[b*8 +: 8];
                end
            end
        end
        rd_nxt = mem_nxt[int'(cfg.rd_idx)*32 +: 32];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mem_r <= {NUM_CHANNELS{CHANNEL_ROUTE_CONFIG_RST}};
            rd_r  <= 32'h0000_0000;
        end else begin
            mem_r <= mem_nxt;
            rd_r  <= rd_nxt;
        end
    end

    assign cfg.rd_data  = rd_r;
    assign cfg.cfg_flat = mem_r;

endmodule // route_cfg_store

// >>> dma_ctrl_model.sv
`timescale 1ns/1ps
// --------
// Channel service model
// --------
module dma_ctrl_model (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Channel side
    input  wire logic        slow,
    input  wire logic [31:0] chan_req,
    output      logic [31:0] serviced
);
    int age_r [32];

    // One pulse per request, after a short or a long service time
    always @(posedge hclk or negedge hresetn) begin
        for (int n = 0; n < 32; n++) begin
            if (!hresetn || !chan_req[n]) begin
                age_r[n]    <= 0;
                serviced[n] <= 1'b0;
            end else begin
                age_r[n]    <= age_r[n] + 1;
                serviced[n] <= age_r[n] == (slow ? 6 : 1);
            end
        end
    end
endmodule // dma_ctrl_model

// >>> tb.sv
`timescale 1ns/1ps
module tb;
    import dma_route_pkg::*;
    // --------
    // Signals
    // --------
    logic        hclk        = 1'b0;
    logic        hresetn     = 1'b0;
    logic        hsel        = 1'b0;
    logic [31:0] haddr       = '0;
    logic [1:0]  htrans      = 2'h0;
    logic        hwrite      = 1'b0;
    logic [2:0]  hsize       = 3'h0;
    logic [31:0] hwdata      = '0;
    logic [63:0] periph_req  = '0;
    logic [3:0]  pit         = 4'h0;
    logic        slow        = 1'b0;
    logic        rd_ph       = 1'b0;
    logic [31:0] rnd         = 32'h4a2b_d20e;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] dma_chan_req;
    logic [31:0] serviced;
    logic [31:0] w;
    logic [5:0]  base;
    logic [7:0]  cfg_exp [32];
    logic [31:0] rd_q [$];
    int          bad_count   = 0;
    int          check_count = 0;
    int          cycles      = 0;

    dma_request_router_trigger DUT (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .periph_req(periph_req), .periodic_interval_timer(pit),
        .dma_chan_req(dma_chan_req));
    dma_ctrl_model partner (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .chan_req(dma_chan_req), .serviced(serviced));

    always #2 hclk = ~hclk;

    // --------
    // Helpers
    // --------
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic exp_req(int n);
        logic [7:0] c;
        c = cfg_exp[n];
        if (!c[7]) return 1'b0;
        if (c[5:0] >= 6'd60) return 1'b1;
        if (c[5:0] == 6'd0 || c[5:0] > 6'd52) return 1'b0;
        return periph_req[c[5:0]];
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic bus(logic wr, logic [31:0] a, logic [2:0] sz,
                       logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
    endtask

    task automatic wr(logic [31:0] a, logic [2:0] sz, logic [31:0] d);
        for (int b = 0; b < 4; b++)
            if (a < 32'h20 && (sz == HSIZE_WORD || b == int'(a[1:0]) ||
                (sz == HSIZE_HALF && 1'(b >> 1) == a[1])))
                cfg_exp[{a[4:2], 2'(b)}] = d[8*b +: 8];
        bus(1'b1, a, sz, d);
    endtask

    task automatic rd(logic [31:0] a);
        rd_q.push_back(a >= 32'h20 ? 32'h0 :
            {cfg_exp[{a[4:2], 2'd3}], cfg_exp[{a[4:2], 2'd2}],
             cfg_exp[{a[4:2], 2'd1}], cfg_exp[{a[4:2], 2'd0}]});
        bus(1'b0, a, HSIZE_WORD, 32'h0);
    endtask

    // Gated channels in trigger mode are left to the directed test
    task automatic chk_route();
        logic [31:0] e;
        logic [31:0] m;
        @(negedge hclk);
        for (int n = 0; n < 32; n++) begin
            m[n] = !(n < 4 && cfg_exp[n][7] && cfg_exp[n][6]);
            e[n] = exp_req(n) & m[n];
        end
        chk("dma_chan_req", dma_chan_req & m, e);
    endtask

    // Read data watcher and hang guard
    always @(posedge hclk) begin
        if (rd_ph) chk("hrdata", hrdata, rd_q.pop_front());
        if (rd_ph) chk("hresp", {31'h0, hresp}, 32'h0);
        if (rd_ph) chk("hreadyout", {31'h0, hreadyout}, 32'h1);
        rd_ph  <= hsel && htrans == HTRANS_NONSEQ && !hwrite;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_of_test();
        end
    end

    // --------
    // Scenarios
    // --------
    initial begin
        for (int n = 0; n < 32; n++) cfg_exp[n] = 8'h00;
        repeat (4) @(posedge hclk);
        hresetn    <= 1'b1;
        periph_req <= '1;
        for (int k = 0; k < 9; k++) rd(32'(4 * k));
        chk_route();
        wr(32'h20, HSIZE_WORD, 32'hffff_ffff);
        wr(32'h06, HSIZE_HALF, 32'h3c80_0000);
        wr(32'h05, HSIZE_BYTE, 32'h0000_bf00);
        wr(32'h04, HSIZE_BYTE, 32'h0000_00bc);
        rd(32'h20);
        rd(32'h04);
        chk_route();
        for (int r = 0; r < 6; r++) begin
            rnd  = lfsr(rnd);
            base = rnd[5:0];
            for (int k = 0; k < 8; k++) begin
                rnd = lfsr(rnd);
                for (int b = 0; b < 4; b++)
                    w[8*b +: 8] = {rnd[2*b +: 2], base + 6'(4*k + b)};
                wr(32'(4 * k), HSIZE_WORD, 32'h0);
                wr(32'(4 * k), HSIZE_WORD, w);
                rd(32'(4 * k));
            end
            periph_req <= {lfsr(rnd), rnd};
            chk_route();
        end
        periph_req <= '0;
        wr(32'h00, HSIZE_WORD, 32'h0);
        wr(32'h00, HSIZE_WORD, 32'hc8c7_c6c5);
        for (int c = 0; c < 4; c++) begin
            slow <= c[0];
            @(posedge hclk);
            pit[c] <= 1'b1;
            @(posedge hclk);
            pit[c] <= 1'b0;
            repeat (2) @(posedge hclk);
            periph_req[5 + c] <= 1'b1;
            repeat (4) @(negedge hclk);
            chk("held", 32'(dma_chan_req[3:0]), 32'h0);
            @(posedge hclk);
            pit[c] <= 1'b1;
            @(posedge hclk);
            pit[c] <= 1'b0;
            @(negedge hclk);
            chk("gate", 32'(dma_chan_req[3:0]), 32'h0);
            @(negedge hclk);
            chk("gate", 32'(dma_chan_req[3:0]), 32'(1 << c));
            for (int t = 0; t < 20 && serviced[c] !== 1'b1; t++)
                @(posedge hclk);
            chk("serviced", 32'(serviced[c]), 32'h1);
            periph_req[5 + c] <= 1'b0;
            @(negedge hclk);
            chk("drop", 32'(dma_chan_req[3:0]), 32'h0);
            repeat (2) @(posedge hclk);
            periph_req[5 + c] <= 1'b1;
            repeat (3) @(negedge hclk);
            chk("reopen", 32'(dma_chan_req[3:0]), 32'h0);
            periph_req[5 + c] <= 1'b0;
        end
        end_of_test();
    end
endmodule // tb
